// ### shared/hlcr_pkg.sv
// Package: register map, field layout, reset values and carrier types of the config bank.
package hlcr_pkg;
  localparam int NREG = 15;
  localparam int AW = 12;
  // Printed offsets are word indices; the byte address is four times the index.
  localparam logic [5:0] IDX_RX_LANE_DELAY_B = 6'h27;
  localparam logic [5:0] IDX_RX_CLOCK_RECOVERY_CTRL = 6'h28;
  localparam logic [5:0] IDX_RX_DLL_CTRL = 6'h29;
  localparam logic [5:0] IDX_TX_POWER_CTRL = 6'h2A;
  localparam logic [5:0] IDX_TX_TERM_CALIB_BIAS = 6'h2B;
  localparam logic [5:0] IDX_PLL_DIVIDER_OVERRIDE = 6'h2C;
  localparam logic [5:0] IDX_IOMMU_REDIRECT_ADDR_A = 6'h2E;
  localparam logic [5:0] IDX_IOMMU_REDIRECT_ADDR_B = 6'h2F;
  localparam logic [5:0] IDX_MEM_TOP_LOW = 6'h30;
  localparam logic [5:0] IDX_MEM_TOP_HIGH = 6'h31;
  localparam logic [5:0] IDX_UNIT_CONFIG = 6'h32;
  localparam logic [5:0] IDX_RX_PHASE_READBACK = 6'h33;
  localparam logic [5:0] IDX_IOMMU_BASE_TAG_MASK = 6'h38;
  localparam logic [5:0] IDX_IOMMU_ISOC_TAG_MASK = 6'h39;
  localparam logic [5:0] IDX_BRIDGE_FATAL_FLOOD_ENABLE = 6'h3A;
  // Storage slots, in the order of the tables below.
  localparam int K_LANE = 0;
  localparam int K_CR = 1;
  localparam int K_DLL = 2;
  localparam int K_TXP = 3;
  localparam int K_TERM = 4;
  localparam int K_PLL = 5;
  localparam int K_RDA = 6;
  localparam int K_RDB = 7;
  localparam int K_MLO = 8;
  localparam int K_MHI = 9;
  localparam int K_UCFG = 10;
  localparam int K_PHRB = 11;
  localparam int K_BTAG = 12;
  localparam int K_ITAG = 13;
  localparam int K_FLOOD = 14;
  localparam logic [NREG-1:0][5:0] REG_IDX = {
    IDX_BRIDGE_FATAL_FLOOD_ENABLE, IDX_IOMMU_ISOC_TAG_MASK, IDX_IOMMU_BASE_TAG_MASK,
    IDX_RX_PHASE_READBACK, IDX_UNIT_CONFIG, IDX_MEM_TOP_HIGH, IDX_MEM_TOP_LOW,
    IDX_IOMMU_REDIRECT_ADDR_B, IDX_IOMMU_REDIRECT_ADDR_A, IDX_PLL_DIVIDER_OVERRIDE,
    IDX_TX_TERM_CALIB_BIAS, IDX_TX_POWER_CTRL, IDX_RX_DLL_CTRL,
    IDX_RX_CLOCK_RECOVERY_CTRL, IDX_RX_LANE_DELAY_B};
  localparam logic [NREG-1:0][31:0] REG_WMASK = {
    32'h00003FFC, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h001F0000, 32'hFFFFFFFF,
    32'h000000FF, 32'hFF800001, 32'hFFFFFFC0, 32'h000FFFFF, 32'h0000BBFF,
    32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  localparam logic [NREG-1:0][31:0] REG_RESET = {
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h80000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h03200000, 32'h17000000, 32'h1980001E, 32'h40280200, 32'h00000000};
  // Field positions.
  localparam int CR_OFFSET_C_BIT = 8;
  localparam int CR_OBS_SEL_BIT = 9;
  localparam int CR_FREQ_LOOP_BIT = 10;
  localparam int CR_FREQ_BYP_BIT = 11;
  localparam int CR_PH_BYP_BIT = 12;
  localparam int CR_FREQ_VAL_LSB = 13;
  localparam int CR_FREQ_FILT_LSB = 19;
  localparam int CR_PH_FILT_LSB = 21;
  localparam int CR_PH_VAL_LSB = 23;
  localparam int CR_TRACK_BIT = 30;
  localparam int CR_SRC_BIT = 31;
  localparam int DLL_BYPASS_BIT = 0;
  localparam int DLL_RST_LSB = 1;
  localparam int DLL_PD_LSB = 3;
  localparam int DLL_CLKSEL_LSB = 5;
  localparam int DLL_RXON_LSB = 23;
  localparam int DLL_SRC_BIT = 25;
  localparam int DLL_PAD_RATE_LSB = 27;
  localparam int TXP_PD_LSB = 6;
  localparam int TXP_SAMPLE_LSB = 27;
  localparam int TERM_DIS_LSB = 0;
  localparam int TERM_INC_LSB = 18;
  localparam int TERM_DEC_LSB = 23;
  localparam int TERM_BIAS_LSB = 28;
  localparam int PLL_FB_LSB = 0;
  localparam int PLL_FB_EN_BIT = 7;
  localparam int PLL_REF_LSB = 8;
  localparam int PLL_REF_EN_BIT = 11;
  localparam int PLL_POST_LSB = 12;
  localparam int PLL_POST_EN_BIT = 15;
  localparam int RDB_LSB = 6;
  localparam int MLO_EN_BIT = 0;
  localparam int MLO_LSB = 23;
  localparam int UCFG_EXT_BAR_BIT = 28;
  localparam int UCFG_CTL_FORCE_BIT = 31;
  localparam int PHRB_SEL_LSB = 16;
  localparam int FLOOD_LO = 2;
  localparam int FLOOD_HI = 13;
  localparam int MEM_ADDR_W = 40;
  localparam int MEM_4GB_BIT = 32;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
  } hlcr_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } hlcr_apb_rsp_s;

  typedef struct packed {
    logic [NREG-1:0][31:0] regs;
    hlcr_apb_rsp_s apb;
    logic mem_hit;
    logic ctl1;
    logic syncflood_req;
    logic [31:0] isoc_tag_avail;
    logic [51:0] redirect_addr;
    logic cr_track_en;
    logic [6:0] phase_eff;
    logic [5:0] freq_eff;
    logic [6:0] cr_observe;
    logic [1:0] dll_reset;
    logic [1:0] dll_power_down;
    logic [1:0] rx_power_on_n;
    logic [6:0] pll_feedback_div;
    logic [1:0] pll_ref_div;
    logic [1:0] pll_core_post_div;
    logic [15:0] tx_bias_en;
  } hlcr_state_s;
endpackage

// ### core/hlcr_config_regs.sv
// Module: APB register bank and control muxing of the host-link unit configuration.
`timescale 1ns/1ps
module hlcr_config_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire hlcr_pkg::hlcr_apb_req_s i_apb,
  output hlcr_pkg::hlcr_apb_rsp_s o_apb,
  input wire logic [hlcr_pkg::MEM_ADDR_W-1:0] i_mem_addr,
  input wire logic i_core_ctl1,
  input wire logic [13:0] i_bridge_fatal,
  input wire logic [31:0] i_isoc_tag_free,
  input wire logic i_core_cr_en,
  input wire logic [6:0] i_phase_cnt,
  input wire logic [5:0] i_freq_est,
  input wire logic [1:0] i_core_dll_reset,
  input wire logic [1:0] i_core_dll_pd,
  input wire logic [1:0] i_core_rx_on_n,
  input wire logic [6:0] i_core_fb_div,
  input wire logic [1:0] i_core_ref_div,
  input wire logic [1:0] i_core_post_div,
  input wire logic [7:0] i_rx_phase_readback,
  output logic o_mem_hit,
  output logic o_ext_cfg_bar_decode_en,
  output logic o_ctl1,
  output logic o_syncflood_req,
  output logic [31:0] o_isoc_tag_avail,
  output logic [31:0] o_base_tag_mask,
  output logic [51:0] o_redirect_addr,
  output logic o_cr_track_en,
  output logic [6:0] o_phase_eff,
  output logic [5:0] o_freq_eff,
  output logic [6:0] o_cr_observe,
  output logic o_freq_loop_en,
  output logic [1:0] o_freq_filter_size,
  output logic [1:0] o_phase_filter_size,
  output logic o_offset_cancel_en,
  output logic o_dll_bypass,
  output logic [17:0] o_dll_clk_sel,
  output logic [1:0] o_dll_reset,
  output logic [1:0] o_dll_power_down,
  output logic [1:0] o_rx_power_on_n,
  output logic [4:0] o_calib_update_rate,
  output logic [4:0] o_calib_sample_delay,
  output logic [4:0] o_calib_upper_limit,
  output logic [4:0] o_calib_lower_limit,
  output logic [6:0] o_pll_feedback_div,
  output logic [1:0] o_pll_ref_div,
  output logic [1:0] o_pll_core_post_div,
  output logic [15:0] o_tx_bias_en,
  output logic o_tx_bias_clk_ctl_en,
  output logic [17:0] o_tx_lane_power_down,
  output logic [17:0] o_tx_lane_term_disable,
  output logic [39:0] o_rx_lane_delay,
  output logic [4:0] o_phase_readback_sel
);
  hlcr_pkg::hlcr_state_s s_reg;
  hlcr_pkg::hlcr_state_s s_next;
  logic apb_setup;
  logic apb_done;
  logic addr_ok;
  logic [hlcr_pkg::MEM_ADDR_W-1:0] upper_mem_limit;
  logic [15:0] bias_lane;

  assign apb_setup = i_apb.psel & ~i_apb.penable;
  // The answer is registered, so every transfer takes exactly one access cycle.
  assign apb_done = i_apb.psel & i_apb.penable & s_reg.apb.pready;
  assign addr_ok = (i_apb.paddr[hlcr_pkg::AW-1:8] == '0) && (i_apb.paddr[1:0] == 2'h0);

  // Low limit bits sit at address bits 31:23, high bits at 39:32, reaching 1TB.
  assign upper_mem_limit = {
    s_reg.regs[hlcr_pkg::K_MHI][7:0],
    s_reg.regs[hlcr_pkg::K_MLO][31:hlcr_pkg::MLO_LSB],
    23'h000000};

  // Bias group 0 drives the clock and control lanes; lanes 2, 6, 10, 14 are always biased.
  for (genvar g = 0; g < 16; g++) begin : g_bias
    if (g % 4 == 2) begin : g_fixed
      assign bias_lane[g] = 1'b1;
    end else if (g % 4 == 3) begin : g_grp3
      assign bias_lane[g] = s_reg.regs[hlcr_pkg::K_TERM][hlcr_pkg::TERM_BIAS_LSB + 3];
    end else if (g % 4 == 1) begin : g_grp2
      assign bias_lane[g] = s_reg.regs[hlcr_pkg::K_TERM][hlcr_pkg::TERM_BIAS_LSB + 2];
    end else begin : g_grp1
      assign bias_lane[g] = s_reg.regs[hlcr_pkg::K_TERM][hlcr_pkg::TERM_BIAS_LSB + 1];
    end
  end

  always_comb begin
    s_next = s_reg;
    // Bus side: answer is prepared in the setup cycle and stands for one access cycle.
    s_next.apb.pready = apb_setup;
    if (apb_setup) begin
      s_next.apb.prdata = 32'h00000000;
      s_next.apb.pslverr = 1'b1;
      for (int k = 0; k < hlcr_pkg::NREG; k++) begin
        if (addr_ok && (i_apb.paddr[7:2] == hlcr_pkg::REG_IDX[k])) begin
          s_next.apb.prdata = s_reg.regs[k];
          s_next.apb.pslverr = 1'b0;
        end
      end
    end else if (apb_done) begin
      s_next.apb.prdata = 32'h00000000;
      s_next.apb.pslverr = 1'b0;
    end
    if (apb_done && i_apb.pwrite) begin
      for (int k = 0; k < hlcr_pkg::NREG; k++) begin
        if (addr_ok && (i_apb.paddr[7:2] == hlcr_pkg::REG_IDX[k])) begin
          s_next.regs[k] = (i_apb.pwdata & hlcr_pkg::REG_WMASK[k]) |
                           (s_reg.regs[k] & ~hlcr_pkg::REG_WMASK[k]);
        end
      end
    end
    // The read-only phase field follows the receiver every cycle.
    s_next.regs[hlcr_pkg::K_PHRB][7:0] = i_rx_phase_readback;

    // Derived controls are registered from the current settings, one cycle behind them; cr_observe picks the registered phase_eff and freq_eff, two cycles behind.
    s_next.mem_hit = s_reg.regs[hlcr_pkg::K_MLO][hlcr_pkg::MLO_EN_BIT] &&
                     (i_mem_addr[hlcr_pkg::MEM_ADDR_W-1:hlcr_pkg::MEM_4GB_BIT] != '0) &&
                     (i_mem_addr < upper_mem_limit);
    s_next.ctl1 = s_reg.regs[hlcr_pkg::K_UCFG][hlcr_pkg::UCFG_CTL_FORCE_BIT] | i_core_ctl1;
    s_next.syncflood_req = |(i_bridge_fatal[hlcr_pkg::FLOOD_HI:hlcr_pkg::FLOOD_LO] &
      s_reg.regs[hlcr_pkg::K_FLOOD][hlcr_pkg::FLOOD_HI:hlcr_pkg::FLOOD_LO]);
    s_next.isoc_tag_avail = i_isoc_tag_free & ~s_reg.regs[hlcr_pkg::K_ITAG];
    s_next.redirect_addr = {s_reg.regs[hlcr_pkg::K_RDA][19:0],
      s_reg.regs[hlcr_pkg::K_RDB][31:hlcr_pkg::RDB_LSB], 6'h00};
    s_next.cr_track_en = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_SRC_BIT] ?
      s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_TRACK_BIT] : i_core_cr_en;
    s_next.phase_eff = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_PH_BYP_BIT] ?
      s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_PH_VAL_LSB +: 7] : i_phase_cnt;
    s_next.freq_eff = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_FREQ_BYP_BIT] ?
      s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_FREQ_VAL_LSB +: 6] : i_freq_est;
    s_next.cr_observe = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_OBS_SEL_BIT] ?
      s_reg.phase_eff : {1'b0, s_reg.freq_eff};
    if (s_reg.regs[hlcr_pkg::K_DLL][hlcr_pkg::DLL_SRC_BIT]) begin
      s_next.dll_reset = s_reg.regs[hlcr_pkg::K_DLL][hlcr_pkg::DLL_RST_LSB +: 2];
      s_next.dll_power_down = s_reg.regs[hlcr_pkg::K_DLL][hlcr_pkg::DLL_PD_LSB +: 2];
      s_next.rx_power_on_n = s_reg.regs[hlcr_pkg::K_DLL][hlcr_pkg::DLL_RXON_LSB +: 2];
    end else begin
      s_next.dll_reset = i_core_dll_reset;
      s_next.dll_power_down = i_core_dll_pd;
      s_next.rx_power_on_n = i_core_rx_on_n;
    end
    s_next.pll_feedback_div = s_reg.regs[hlcr_pkg::K_PLL][hlcr_pkg::PLL_FB_EN_BIT] ?
      s_reg.regs[hlcr_pkg::K_PLL][hlcr_pkg::PLL_FB_LSB +: 7] : i_core_fb_div;
    s_next.pll_ref_div = s_reg.regs[hlcr_pkg::K_PLL][hlcr_pkg::PLL_REF_EN_BIT] ?
      s_reg.regs[hlcr_pkg::K_PLL][hlcr_pkg::PLL_REF_LSB +: 2] : i_core_ref_div;
    s_next.pll_core_post_div = s_reg.regs[hlcr_pkg::K_PLL][hlcr_pkg::PLL_POST_EN_BIT] ?
      s_reg.regs[hlcr_pkg::K_PLL][hlcr_pkg::PLL_POST_LSB +: 2] : i_core_post_div;
    s_next.tx_bias_en = bias_lane;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg <= '{regs: hlcr_pkg::REG_RESET, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Plain settings leave straight from their register bits.
  assign o_apb = s_reg.apb;
  assign o_mem_hit = s_reg.mem_hit;
  assign o_ext_cfg_bar_decode_en = s_reg.regs[hlcr_pkg::K_UCFG][hlcr_pkg::UCFG_EXT_BAR_BIT];
  assign o_ctl1 = s_reg.ctl1;
  assign o_syncflood_req = s_reg.syncflood_req;
  assign o_isoc_tag_avail = s_reg.isoc_tag_avail;
  assign o_base_tag_mask = s_reg.regs[hlcr_pkg::K_BTAG];
  assign o_redirect_addr = s_reg.redirect_addr;
  assign o_cr_track_en = s_reg.cr_track_en;
  assign o_phase_eff = s_reg.phase_eff;
  assign o_freq_eff = s_reg.freq_eff;
  assign o_cr_observe = s_reg.cr_observe;
  assign o_freq_loop_en = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_FREQ_LOOP_BIT];
  assign o_freq_filter_size = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_FREQ_FILT_LSB +: 2];
  assign o_phase_filter_size = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_PH_FILT_LSB +: 2];
  assign o_offset_cancel_en = s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_OFFSET_C_BIT];
  assign o_dll_bypass = s_reg.regs[hlcr_pkg::K_DLL][hlcr_pkg::DLL_BYPASS_BIT];
  assign o_dll_clk_sel = s_reg.regs[hlcr_pkg::K_DLL][hlcr_pkg::DLL_CLKSEL_LSB +: 18];
  assign o_dll_reset = s_reg.dll_reset;
  assign o_dll_power_down = s_reg.dll_power_down;
  assign o_rx_power_on_n = s_reg.rx_power_on_n;
  assign o_calib_update_rate = s_reg.regs[hlcr_pkg::K_DLL][hlcr_pkg::DLL_PAD_RATE_LSB +: 5];
  assign o_calib_sample_delay = s_reg.regs[hlcr_pkg::K_TXP][hlcr_pkg::TXP_SAMPLE_LSB +: 5];
  assign o_calib_upper_limit = s_reg.regs[hlcr_pkg::K_TERM][hlcr_pkg::TERM_INC_LSB +: 5];
  assign o_calib_lower_limit = s_reg.regs[hlcr_pkg::K_TERM][hlcr_pkg::TERM_DEC_LSB +: 5];
  assign o_pll_feedback_div = s_reg.pll_feedback_div;
  assign o_pll_ref_div = s_reg.pll_ref_div;
  assign o_pll_core_post_div = s_reg.pll_core_post_div;
  assign o_tx_bias_en = s_reg.tx_bias_en;
  assign o_tx_bias_clk_ctl_en = s_reg.regs[hlcr_pkg::K_TERM][hlcr_pkg::TERM_BIAS_LSB];
  assign o_tx_lane_power_down = s_reg.regs[hlcr_pkg::K_TXP][hlcr_pkg::TXP_PD_LSB +: 18];
  assign o_tx_lane_term_disable = s_reg.regs[hlcr_pkg::K_TERM][hlcr_pkg::TERM_DIS_LSB +: 18];
  assign o_rx_lane_delay = {s_reg.regs[hlcr_pkg::K_CR][7:0], s_reg.regs[hlcr_pkg::K_LANE]};
  assign o_phase_readback_sel = s_reg.regs[hlcr_pkg::K_PHRB][hlcr_pkg::PHRB_SEL_LSB +: 5];

  mem_window_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_mem_hit |-> $past(i_mem_addr) >= 40'h0100000000 &&
      $past(i_mem_addr) < $past(upper_mem_limit))
    else $error("memory hit outside the decode window");
  ctl_force_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    // Derived outputs still hold their reset value one edge after release, hence the guard.
    i_rst_b && s_reg.regs[hlcr_pkg::K_UCFG][hlcr_pkg::UCFG_CTL_FORCE_BIT] |=> o_ctl1)
    else $error("control line not forced high");
  flood_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_syncflood_req |-> $past(i_bridge_fatal[13:2] & s_reg.regs[hlcr_pkg::K_FLOOD][13:2]) != '0)
    else $error("syncflood without an enabled fatal error");
  isoc_mask_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_rst_b |=> (o_isoc_tag_avail & $past(s_reg.regs[hlcr_pkg::K_ITAG])) == 32'h00000000)
    else $error("masked isochronous tag offered");
  cr_source_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_rst_b && !s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_SRC_BIT] |=>
      o_cr_track_en == $past(i_core_cr_en))
    else $error("tracking enable not from core");
  phase_bypass_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_PH_BYP_BIT] |=>
      o_phase_eff == $past(s_reg.regs[hlcr_pkg::K_CR][29:23]))
    else $error("phase bypass value not applied");
  freq_bypass_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_rst_b && !s_reg.regs[hlcr_pkg::K_CR][hlcr_pkg::CR_FREQ_BYP_BIT] |=>
      o_freq_eff == $past(i_freq_est))
    else $error("frequency estimator not passed through");
  pll_override_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_rst_b && !s_reg.regs[hlcr_pkg::K_PLL][hlcr_pkg::PLL_FB_EN_BIT] |=>
      o_pll_feedback_div == $past(i_core_fb_div))
    else $error("feedback divider overridden while disabled");
  bias_fixed_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_rst_b |=> (o_tx_bias_en[2] && o_tx_bias_en[6] && o_tx_bias_en[10] && o_tx_bias_en[14]))
    else $error("fixed bias lane disabled");
  apb_answer_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (apb_setup && !addr_ok) |=> o_apb.pready && o_apb.pslverr && o_apb.prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule // hlcr_config_regs

// ### testbench/hlcr_tb.sv
// Self-checking testbench of the host-link unit configuration register bank.
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk, i_rst_b, i_core_ctl1, i_core_cr_en;
  hlcr_pkg::hlcr_apb_req_s i_apb;
  hlcr_pkg::hlcr_apb_rsp_s o_apb;
  logic [39:0] i_mem_addr, o_rx_lane_delay;
  logic [13:0] i_bridge_fatal;
  logic [31:0] i_isoc_tag_free, o_isoc_tag_avail, o_base_tag_mask;
  logic [6:0] i_phase_cnt, i_core_fb_div, o_phase_eff, o_cr_observe, o_pll_feedback_div;
  logic [5:0] i_freq_est, o_freq_eff;
  logic [1:0] i_core_dll_reset, i_core_dll_pd, i_core_rx_on_n, i_core_ref_div, i_core_post_div;
  logic [1:0] o_freq_filter_size, o_phase_filter_size, o_dll_reset, o_dll_power_down;
  logic [1:0] o_rx_power_on_n, o_pll_ref_div, o_pll_core_post_div;
  logic [7:0] i_rx_phase_readback;
  logic o_mem_hit, o_ext_cfg_bar_decode_en, o_ctl1, o_syncflood_req, o_cr_track_en;
  logic o_freq_loop_en, o_offset_cancel_en, o_dll_bypass, o_tx_bias_clk_ctl_en;
  logic [17:0] o_dll_clk_sel, o_tx_lane_power_down, o_tx_lane_term_disable;
  logic [4:0] o_calib_update_rate, o_calib_sample_delay, o_calib_upper_limit;
  logic [4:0] o_calib_lower_limit, o_phase_readback_sel;
  logic [15:0] o_tx_bias_en;
  logic [51:0] o_redirect_addr;
  logic [33:0] expq[$];
  logic [33:0] e;
  int n_mismatch = 0;
  int comparisons = 0;
  integer seed = 32'h6AF7;

  hlcr_config_regs DUT (.i_sys_clk, .i_rst_b, .i_apb, .o_apb, .i_mem_addr, .i_core_ctl1,
    .i_bridge_fatal, .i_isoc_tag_free, .i_core_cr_en, .i_phase_cnt, .i_freq_est,
    .i_core_dll_reset, .i_core_dll_pd, .i_core_rx_on_n, .i_core_fb_div, .i_core_ref_div,
    .i_core_post_div, .i_rx_phase_readback, .o_mem_hit, .o_ext_cfg_bar_decode_en, .o_ctl1,
    .o_syncflood_req, .o_isoc_tag_avail, .o_base_tag_mask, .o_redirect_addr, .o_cr_track_en,
    .o_phase_eff, .o_freq_eff, .o_cr_observe, .o_freq_loop_en, .o_freq_filter_size,
    .o_phase_filter_size, .o_offset_cancel_en, .o_dll_bypass, .o_dll_clk_sel, .o_dll_reset,
    .o_dll_power_down, .o_rx_power_on_n, .o_calib_update_rate, .o_calib_sample_delay,
    .o_calib_upper_limit, .o_calib_lower_limit, .o_pll_feedback_div, .o_pll_ref_div,
    .o_pll_core_post_div, .o_tx_bias_en, .o_tx_bias_clk_ctl_en, .o_tx_lane_power_down,
    .o_tx_lane_term_disable, .o_rx_lane_delay, .o_phase_readback_sel);

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic note(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Every transfer notes its expected answer: {check data, error flag, data}.
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
      input logic [33:0] exp);
    int n;
    @(posedge i_sys_clk);
    i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    expq.push_back(exp);
    @(posedge i_sys_clk);
    i_apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_apb.pready !== 1'b1 && n < 20);
    if (n >= 20) note(64'h0, 64'h1, "pready never came");
    i_apb.psel <= 1'b0;
    i_apb.penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    xfer(1'b1, {4'h0, idx, 2'b00}, d, {2'b00, 32'h0});
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] d);
    xfer(1'b0, {4'h0, idx, 2'b00}, 32'h0, {2'b10, d});
  endtask

  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask

  // The readback byte of the phase register is live, so it shows the input.
  function automatic logic [31:0] live(input int k);
    return (k == hlcr_pkg::K_PHRB) ? {24'h0, i_rx_phase_readback} : 32'h0;
  endfunction

  task automatic shake(input bit at_edge);
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    if (at_edge) @(posedge i_sys_clk);
    {i_core_ctl1, i_core_cr_en, i_bridge_fatal, i_phase_cnt, i_freq_est, i_core_dll_reset,
      i_core_dll_pd, i_core_rx_on_n, i_core_fb_div, i_core_ref_div, i_core_post_div,
      i_rx_phase_readback, i_isoc_tag_free} <= r[85:0];
  endtask

  task automatic reset_check();
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    for (int k = 0; k < hlcr_pkg::NREG; k++) begin
      rd(hlcr_pkg::REG_IDX[k], hlcr_pkg::REG_RESET[k] | live(k));
    end
    settle();
    note(o_ctl1, 1'b1, "forced control line");
    note(o_tx_bias_en, 16'h4444, "fixed bias lanes");
    note(o_freq_loop_en, 1'b0, "frequency loop");
    note(o_cr_observe, i_phase_cnt, "observe default");
    note(o_cr_track_en, i_core_cr_en, "track source");
    $display("test reset_defaults done");
  endtask

  always @(posedge i_sys_clk) begin
    if (i_rst_b === 1'b1 && o_apb.pready === 1'b1) begin
      if (expq.size() == 0) begin
        note(64'h0, 64'h1, "unexpected pready");
      end else begin
        e = expq.pop_front();
        note(o_apb.pslverr, e[32], "pslverr");
        if (e[33]) note(o_apb.prdata, e[31:0], "prdata");
      end
    end
  end

  initial begin
    repeat (40000) @(posedge i_sys_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [31:0] w[hlcr_pkg::NREG];
    logic [31:0] cr, dl, tm, pl;
    logic [39:0] lim, a;
    logic [15:0] bias;
    logic [6:0] ph;
    logic [5:0] fr;
    i_rst_b = 1'b0;
    i_apb = '0;
    i_mem_addr = 40'h0;
    shake(1'b0);
    reset_check();
    for (int it = 0; it < 8; it++) begin
      shake(1'b1);
      for (int k = 0; k < hlcr_pkg::NREG; k++) begin
        w[k] = $random(seed);
        wr(hlcr_pkg::REG_IDX[k], w[k]);
      end
      settle();
      cr = w[hlcr_pkg::K_CR];
      dl = w[hlcr_pkg::K_DLL];
      tm = w[hlcr_pkg::K_TERM];
      pl = w[hlcr_pkg::K_PLL];
      ph = cr[12] ? cr[29:23] : i_phase_cnt;
      fr = cr[11] ? cr[18:13] : i_freq_est;
      for (int g = 0; g < 16; g++) bias[g] = (g % 4 == 2) || tm[(g % 4 == 3) ? 31 : 29 + g % 4];
      note(o_ext_cfg_bar_decode_en, w[hlcr_pkg::K_UCFG][28], "bar decode");
      note(o_ctl1, w[hlcr_pkg::K_UCFG][31] | i_core_ctl1, "control line");
      note(o_syncflood_req, |(i_bridge_fatal[13:2] & w[hlcr_pkg::K_FLOOD][13:2]), "flood");
      note(o_isoc_tag_avail, i_isoc_tag_free & ~w[hlcr_pkg::K_ITAG], "isoc tags");
      note(o_base_tag_mask, w[hlcr_pkg::K_BTAG], "base tags");
      note(o_redirect_addr, {w[hlcr_pkg::K_RDA][19:0], w[hlcr_pkg::K_RDB][31:6], 6'h00},
        "redirect");
      note(o_cr_track_en, cr[31] ? cr[30] : i_core_cr_en, "track");
      note(o_phase_eff, ph, "phase bypass");
      note(o_freq_eff, fr, "freq bypass");
      note(o_cr_observe, cr[9] ? ph : {1'b0, fr}, "observe");
      note(o_freq_loop_en, cr[10], "frequency loop");
      note({o_phase_filter_size, o_freq_filter_size}, cr[22:19], "filters");
      note(o_offset_cancel_en, cr[8], "offset cancel");
      note({o_dll_reset, o_dll_power_down, o_rx_power_on_n}, dl[25] ? {dl[2:1], dl[4:3],
        dl[24:23]} : {i_core_dll_reset, i_core_dll_pd, i_core_rx_on_n}, "dll");
      note({o_calib_update_rate, o_calib_sample_delay, o_calib_upper_limit, o_calib_lower_limit},
        {dl[31:27], w[hlcr_pkg::K_TXP][31:27], tm[22:18], tm[27:23]}, "calibration");
      note({o_pll_feedback_div, o_pll_ref_div, o_pll_core_post_div}, {pl[7] ? pl[6:0] :
        i_core_fb_div, pl[11] ? pl[9:8] : i_core_ref_div, pl[15] ? pl[13:12] :
        i_core_post_div}, "pll");
      note(o_tx_bias_en, bias, "bias");
      note(o_rx_lane_delay, {cr[7:0], w[hlcr_pkg::K_LANE]}, "lane delay");
      note({o_tx_lane_power_down, o_tx_lane_term_disable}, {w[hlcr_pkg::K_TXP][23:6],
        tm[17:0]}, "lane power");
      note({o_dll_bypass, o_dll_clk_sel, o_tx_bias_clk_ctl_en, o_phase_readback_sel},
        {dl[0], dl[22:5], tm[28], w[hlcr_pkg::K_PHRB][20:16]}, "misc fields");
      for (int k = 0; k < hlcr_pkg::NREG; k++) begin
        rd(hlcr_pkg::REG_IDX[k], (w[k] & hlcr_pkg::REG_WMASK[k]) | live(k));
      end
    end
    $display("test random_fields done");
    // Refused accesses must leave the bank untouched.
    xfer(1'b1, 12'h0B4, 32'hFFFFFFFF, {2'b01, 32'h0});
    xfer(1'b1, 12'h8C8, 32'h0, {2'b01, 32'h0});
    xfer(1'b0, 12'h09E, 32'h0, {2'b11, 32'h0});
    rd(hlcr_pkg::IDX_UNIT_CONFIG, w[hlcr_pkg::K_UCFG] & hlcr_pkg::REG_WMASK[hlcr_pkg::K_UCFG]);
    $display("test refused_access done");
    wr(hlcr_pkg::IDX_BRIDGE_FATAL_FLOOD_ENABLE, 32'hFFFFFFFF);
    for (int n = 0; n < 14; n++) begin
      @(posedge i_sys_clk);
      i_bridge_fatal <= 14'h1 << n;
      settle();
      note(o_syncflood_req, n >= 2, "flood per bridge");
    end
    $display("test flood_sweep done");
    wr(hlcr_pkg::IDX_MEM_TOP_LOW, 32'hD2800001);
    wr(hlcr_pkg::IDX_MEM_TOP_HIGH, 32'h00000003);
    lim = {8'h03, 9'h1A5, 23'h0};
    for (int j = 0; j < 5; j++) begin
      if (j == 4) wr(hlcr_pkg::IDX_MEM_TOP_LOW, 32'hD2800000);
      a = (j == 1) ? lim : (j == 2) ? 40'h0100000000 : (j == 3) ? 40'h00FFFFFFFF : lim - 1;
      @(posedge i_sys_clk);
      i_mem_addr <= a;
      settle();
      note(o_mem_hit, j < 4 && a >= 40'h0100000000 && a < lim, "memory decode");
    end
    $display("test memory_limit done");
    reset_check();
    complete_run();
  end
endmodule // testbench
